// >>> rtl/luntc_pin_watch.sv
module luntc_pin_watch
    import luntc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire luntc_pins_t i_pins,
    output luntc_watch_t o_watch
);

    luntc_watch_state_t s;
    luntc_watch_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.prev = i_pins;
        next_s.ev.latch_rise = (i_pins.ale && !s.prev.ale) || (i_pins.cle && !s.prev.cle)
                               || (i_pins.ce_n && !s.prev.ce_n);
        next_s.ev.strobe_tgl = i_pins.dqs != s.prev.dqs;
        next_s.ev.re_tgl = i_pins.read_enable_n != s.prev.read_enable_n;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{prev: LUNTC_PINS_IDLE, ev: '0};
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    assign o_watch = s.ev;

endmodule : luntc_pin_watch

// >>> rtl/luntc_pkg.sv
package luntc_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] LUNTC_OFS_CTRL = 5'h00;
    localparam logic [4:0] LUNTC_OFS_MASK_LO = 5'h04;
    localparam logic [4:0] LUNTC_OFS_MASK_HI = 5'h08;
    localparam logic [4:0] LUNTC_OFS_DATA_CODE = 5'h0C;
    localparam logic [4:0] LUNTC_OFS_RS_CODE = 5'h10;
    localparam logic [4:0] LUNTC_OFS_OWN_VOL = 5'h14;
    localparam logic [4:0] LUNTC_OFS_STATUS = 5'h18;

    // Control register field positions.
    localparam int LUNTC_CTRL_FEAT_EN = 0;
    localparam int LUNTC_CTRL_MATRIX = 1;
    localparam int LUNTC_CTRL_SELF_BACK = 2;

    // Status register field positions.
    localparam int LUNTC_STAT_FEAT_EN = 0;
    localparam int LUNTC_STAT_MATRIX = 1;
    localparam int LUNTC_STAT_DQ_EN = 2;
    localparam int LUNTC_STAT_RE_EN = 3;
    localparam int LUNTC_STAT_STATE_LO = 4;
    localparam int LUNTC_STAT_VOL_LO = 8;

    // Values after reset.
    localparam logic [7:0] LUNTC_RST_BYTE = 8'h00;
    localparam logic [3:0] LUNTC_RST_VOL = 4'h0;
    localparam logic [31:0] LUNTC_RST_RDATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        LUNTC_ST_DESEL,
        LUNTC_ST_SNIFF,
        LUNTC_ST_SEL
    } luntc_lun_st_t;

    // Shared bus pins as seen by this LUN.
    typedef struct packed {
        logic ale;
        logic cle;
        logic ce_n;
        logic dqs;
        logic read_enable_n;
    } luntc_pins_t;

    // Idle level of the shared pins, so the edge finder reports no event right after reset.
    localparam luntc_pins_t LUNTC_PINS_IDLE = '{ale: 1'b0, cle: 1'b0, ce_n: 1'b1, dqs: 1'b0, read_enable_n: 1'b1};

    // Command context from the LUN core.
    typedef struct packed {
        logic valid;
        logic [3:0] vol;
        logic exec;
        logic burst;
        logic dir_out;
    } luntc_cmd_t;

    // Registered pin events from the pin watcher.
    typedef struct packed {
        logic latch_rise;
        logic strobe_tgl;
        logic re_tgl;
    } luntc_watch_t;

    typedef struct packed {
        luntc_pins_t prev;
        luntc_watch_t ev;
    } luntc_watch_state_t;

    // Termination drive to the pad controls.
    typedef struct packed {
        logic dq_en;
        logic [3:0] dq_code;
        logic re_en;
        logic [3:0] re_code;
    } luntc_term_t;

endpackage : luntc_pkg

// >>> rtl/luntc_top.sv
// Summary of operation
// R1 - Self mode: only executing LUN terminates.
// R2 - Host enables self mode via feature write.
// R3 - Configure command switches target to matrix mode.
// R4 - Matrix: classify selected, sniff or deselected.
// R5 - Terminate for own or other volume.
// R6 - Configured non-executing LUNs on volume terminate.
// R7 - Selected LUN uses burst and cycle state.
// R8 - Sniff LUN decides from latch, strobe pins.
// R9 - Host picks roles and codes per LUN.
// R10 - Separate output and input codes by direction.
// R11 - Low mask bit n means volume n.
// R12 - Upper nibble output code, lower input code.
// R13 - Read strobe byte selects read pair code.
// R14 - All-zero configuration never terminates.
// R15 - Termination only in data cycles.
// R16 - Latch or chip enable rise disables termination.
// R17 - Enabling feature defaults to self mode.
// R18 - Host configures every target, uses volumes.
// R19 - Sniff: toggle with latches low enables.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
module luntc_top
    import luntc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CLK_EN,
    input wire logic [4:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire luntc_pins_t I_PINS,
    input wire luntc_cmd_t I_CMD,
    input wire logic I_CFG_CMD,
    output luntc_term_t O_TERM,
    output luntc_lun_st_t O_LUN_STATE,
    output logic O_MATRIX
);

    typedef struct packed {
        logic feat_en;
        logic matrix;
        logic [7:0] volume_mask_low;
        logic [7:0] volume_mask_high;
        logic [7:0] data_termination_code;
        logic [7:0] read_strobe_termination_code;
        logic [3:0] own_vol;
        luntc_lun_st_t lun_st;
        logic sel_term;
        logic sniff_on;
        logic sniff_out;
        luntc_term_t term;
        logic waitreq;
        logic [31:0] rdata;
    } luntc_state_t;

    logic rst_meta_n;
    logic rst_n;
    luntc_state_t s;
    luntc_state_t next_s;
    luntc_watch_t watch;
    logic data_cycle_now;

    function automatic logic vol_hit(input logic [7:0] lo, input logic [7:0] hi, input logic [3:0] vol);
        logic [15:0] mask;
        mask = {hi, lo};
        return mask[vol];
    endfunction : vol_hit

    function automatic logic cfg_live(input luntc_state_t st);
        return ({st.volume_mask_low, st.volume_mask_high, st.data_termination_code,
                 st.read_strobe_termination_code} != 32'h0000_0000);
    endfunction : cfg_live

    function automatic logic [3:0] dq_pick(input logic [7:0] code, input logic dir_out);
        return dir_out ? code[7:4] : code[3:0];
    endfunction : dq_pick

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    luntc_pin_watch u_pin_watch (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_clk_en(I_CLK_EN),
        .i_pins(I_PINS),
        .o_watch(watch)
    );

    always_comb begin
        logic data_cycle;
        logic active;
        logic dir_out;
        logic is_sel;
        logic is_term;
        data_cycle = 1'b0;
        active = 1'b0;
        dir_out = 1'b0;
        is_sel = 1'b0;
        is_term = 1'b0;
        next_s = s;

        // The request is taken one cycle after it appears; the write lands when waitrequest is seen low.
        if (s.waitreq && (I_AVS_READ || I_AVS_WRITE)) begin
            next_s.waitreq = 1'b0;
            next_s.rdata = LUNTC_RST_RDATA;
            if (I_AVS_READ) begin
                unique case (I_AVS_ADDRESS)
                    LUNTC_OFS_CTRL: begin
                        next_s.rdata[LUNTC_CTRL_FEAT_EN] = s.feat_en;
                        next_s.rdata[LUNTC_CTRL_MATRIX] = s.matrix;
                    end
                    LUNTC_OFS_MASK_LO: next_s.rdata[7:0] = s.volume_mask_low;
                    LUNTC_OFS_MASK_HI: next_s.rdata[7:0] = s.volume_mask_high;
                    LUNTC_OFS_DATA_CODE: next_s.rdata[7:0] = s.data_termination_code;
                    LUNTC_OFS_RS_CODE: next_s.rdata[7:0] = s.read_strobe_termination_code;
                    LUNTC_OFS_OWN_VOL: next_s.rdata[3:0] = s.own_vol;
                    LUNTC_OFS_STATUS: begin
                        next_s.rdata[LUNTC_STAT_FEAT_EN] = s.feat_en;
                        next_s.rdata[LUNTC_STAT_MATRIX] = s.matrix;
                        next_s.rdata[LUNTC_STAT_DQ_EN] = s.term.dq_en;
                        next_s.rdata[LUNTC_STAT_RE_EN] = s.term.re_en;
                        next_s.rdata[LUNTC_STAT_STATE_LO +: 2] = s.lun_st;
                        next_s.rdata[LUNTC_STAT_VOL_LO +: 4] = s.own_vol;
                    end
                    default: next_s.rdata = LUNTC_RST_RDATA;
                endcase
            end
        end else if (!s.waitreq) begin
            next_s.waitreq = 1'b1;
            if (I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
                unique case (I_AVS_ADDRESS)
                    LUNTC_OFS_CTRL: begin
                        next_s.feat_en = I_AVS_WRITEDATA[LUNTC_CTRL_FEAT_EN];
                        // Turning the feature on starts in self mode.
                        if (I_AVS_WRITEDATA[LUNTC_CTRL_FEAT_EN] && !s.feat_en) begin // R17
                            next_s.matrix = 1'b0;
                        end
                        if (I_AVS_WRITEDATA[LUNTC_CTRL_SELF_BACK]) begin
                            next_s.matrix = 1'b0;
                        end
                    end
                    LUNTC_OFS_MASK_LO: next_s.volume_mask_low = I_AVS_WRITEDATA[7:0];
                    LUNTC_OFS_MASK_HI: next_s.volume_mask_high = I_AVS_WRITEDATA[7:0];
                    LUNTC_OFS_DATA_CODE: next_s.data_termination_code = I_AVS_WRITEDATA[7:0];
                    LUNTC_OFS_RS_CODE: next_s.read_strobe_termination_code = I_AVS_WRITEDATA[7:0];
                    LUNTC_OFS_OWN_VOL: next_s.own_vol = I_AVS_WRITEDATA[3:0];
                    default: next_s.own_vol = s.own_vol;
                endcase
            end
        end

        // A configure command seen in the same cycle as a clear still wins.
        if (I_CFG_CMD) begin // R3
            next_s.matrix = 1'b1;
        end

        // Classify this LUN on every command while the matrix is in use.
        if (I_CMD.valid) begin
            is_sel = I_CMD.vol == s.own_vol;
            is_term = vol_hit(s.volume_mask_low, s.volume_mask_high, I_CMD.vol) && cfg_live(s); // R5 R11 R14
            next_s.sel_term = is_sel && is_term; // R6
            next_s.sniff_on = 1'b0;
            if (!s.matrix) begin
                next_s.lun_st = LUNTC_ST_DESEL;
            end else if (is_sel) begin // R4
                next_s.lun_st = LUNTC_ST_SEL;
            end else if (is_term) begin
                next_s.lun_st = LUNTC_ST_SNIFF;
            end else begin
                next_s.lun_st = LUNTC_ST_DESEL;
            end
        end

        data_cycle = !I_PINS.ale && !I_PINS.cle && !I_PINS.ce_n; // R15

        // The sniffing LUN sees only the pins; a latch rise ends its window.
        if (s.lun_st == LUNTC_ST_SNIFF && !I_CMD.valid) begin // R8
            if (watch.latch_rise || !data_cycle) begin // R16 R19
                next_s.sniff_on = 1'b0;
            end else if (watch.strobe_tgl || watch.re_tgl) begin // R19
                next_s.sniff_on = 1'b1;
                next_s.sniff_out = watch.re_tgl;
            end
        end

        if (s.feat_en && !s.matrix) begin
            active = I_CMD.exec && I_CMD.burst && data_cycle; // R1 R15
            dir_out = I_CMD.dir_out;
        end else if (s.feat_en && s.lun_st == LUNTC_ST_SEL) begin
            active = s.sel_term && I_CMD.burst && data_cycle; // R6 R7
            dir_out = I_CMD.dir_out;
        end else if (s.feat_en && s.lun_st == LUNTC_ST_SNIFF) begin
            active = s.sniff_on && data_cycle && !watch.latch_rise; // R8
            dir_out = s.sniff_out;
        end

        if (watch.latch_rise) begin // R16
            active = 1'b0;
        end

        next_s.term.dq_code = dq_pick(s.data_termination_code, dir_out); // R10 R12
        next_s.term.dq_en = active && (next_s.term.dq_code != 4'h0);
        next_s.term.re_code = s.read_strobe_termination_code[3:0]; // R13
        next_s.term.re_en = active && dir_out && (next_s.term.re_code != 4'h0);
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{
                feat_en: 1'b0,
                matrix: 1'b0,
                volume_mask_low: LUNTC_RST_BYTE,
                volume_mask_high: LUNTC_RST_BYTE,
                data_termination_code: LUNTC_RST_BYTE,
                read_strobe_termination_code: LUNTC_RST_BYTE,
                own_vol: LUNTC_RST_VOL,
                lun_st: LUNTC_ST_DESEL,
                sel_term: 1'b0,
                sniff_on: 1'b0,
                sniff_out: 1'b0,
                term: '0,
                waitreq: 1'b1,
                rdata: LUNTC_RST_RDATA
            };
        end else if (I_CLK_EN) begin
            s <= next_s;
        end
    end

    assign O_AVS_READDATA = s.rdata;
    assign O_AVS_WAITREQUEST = s.waitreq;
    assign O_TERM = s.term;
    assign O_LUN_STATE = s.lun_st;
    assign O_MATRIX = s.matrix;
    assign data_cycle_now = !I_PINS.ale && !I_PINS.cle && !I_PINS.ce_n;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!rst_n);

    property p_self_only_exec;
        I_CLK_EN && s.feat_en && !s.matrix && !I_CMD.exec |=> !O_TERM.dq_en && !O_TERM.re_en;
    endproperty
    a_self_only_exec: assert property (p_self_only_exec) else $error("Non-executing LUN terminated in self mode."); // R1

    property p_cfg_to_matrix;
        I_CLK_EN && I_CFG_CMD |=> O_MATRIX;
    endproperty
    a_cfg_to_matrix: assert property (p_cfg_to_matrix) else $error("Configure command did not select matrix mode."); // R3

    property p_classify_sel;
        I_CLK_EN && s.matrix && !I_CFG_CMD && I_CMD.valid && I_CMD.vol == s.own_vol |=> O_LUN_STATE == LUNTC_ST_SEL;
    endproperty
    a_classify_sel: assert property (p_classify_sel) else $error("Addressed LUN not selected."); // R4

    property p_classify_sniff;
        I_CLK_EN && s.matrix && I_CMD.valid && I_CMD.vol != s.own_vol && cfg_live(s)
            && vol_hit(s.volume_mask_low, s.volume_mask_high, I_CMD.vol) |=> O_LUN_STATE == LUNTC_ST_SNIFF;
    endproperty
    a_classify_sniff: assert property (p_classify_sniff) else $error("Terminator LUN not in sniff state."); // R11

    property p_zero_cfg;
        I_CLK_EN && s.matrix && !cfg_live(s) |=> !O_TERM.dq_en && !O_TERM.re_en;
    endproperty
    a_zero_cfg: assert property (p_zero_cfg) else $error("Unconfigured LUN terminated."); // R14

    property p_cmd_cycle_off;
        I_CLK_EN && (I_PINS.ale || I_PINS.cle || I_PINS.ce_n) |=> !O_TERM.dq_en && !O_TERM.re_en;
    endproperty
    a_cmd_cycle_off: assert property (p_cmd_cycle_off) else $error("Termination on outside data cycle."); // R15

    property p_rise_off;
        I_CLK_EN && watch.latch_rise |=> !O_TERM.dq_en;
    endproperty
    a_rise_off: assert property (p_rise_off) else $error("Termination kept after latch rise."); // R16

    property p_dir_code;
        I_CLK_EN && s.feat_en && !s.matrix && I_CMD.exec && I_CMD.burst && data_cycle_now && !watch.latch_rise
            |=> O_TERM.dq_code == ($past(I_CMD.dir_out) ? $past(s.data_termination_code[7:4])
                                                       : $past(s.data_termination_code[3:0]));
    endproperty
    a_dir_code: assert property (p_dir_code) else $error("Wrong direction code applied."); // R10

    property p_sniff_on;
        I_CLK_EN && s.feat_en && s.lun_st == LUNTC_ST_SNIFF && !I_CMD.valid && data_cycle_now && !watch.latch_rise
            && watch.re_tgl ##1 I_CLK_EN && s.feat_en && s.matrix && data_cycle_now
            && !watch.latch_rise && !I_CMD.valid
            |=> O_TERM.dq_en == ($past(s.data_termination_code[7:4]) != 4'h0);
    endproperty
    a_sniff_on: assert property (p_sniff_on) else $error("Sniff LUN missed data output burst."); // R19

    property p_bus_answer;
        I_CLK_EN && O_AVS_WAITREQUEST && (I_AVS_READ || I_AVS_WRITE) |=> !O_AVS_WAITREQUEST;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("Bus request not answered in one cycle.");

    property p_desel_quiet;
        I_CLK_EN && s.feat_en && s.matrix && s.lun_st == LUNTC_ST_DESEL |=> !O_TERM.dq_en && !O_TERM.re_en;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet) else $error("Deselected LUN terminated."); // R4

    property p_sel_terminator;
        I_CLK_EN && s.feat_en && s.matrix && s.lun_st == LUNTC_ST_SEL && s.sel_term && I_CMD.burst
            && !I_CMD.dir_out && s.data_termination_code[3:0] != 4'h0 && data_cycle_now && !watch.latch_rise
            |=> O_TERM.dq_en;
    endproperty
    a_sel_terminator: assert property (p_sel_terminator) else $error("Selected terminator stayed off."); // R6

    property p_feature_off;
        I_CLK_EN && !s.feat_en |=> !O_TERM.dq_en && !O_TERM.re_en;
    endproperty
    a_feature_off: assert property (p_feature_off) else $error("Termination on with feature off."); // R2

    property p_re_output_only;
        I_CLK_EN && s.feat_en && !s.matrix && !I_CMD.dir_out |=> !O_TERM.re_en;
    endproperty
    a_re_output_only: assert property (p_re_output_only) else $error("Read pair terminated on input."); // R10

    property p_enable_self;
        I_CLK_EN && !s.feat_en && !I_CFG_CMD && I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0]
            && I_AVS_ADDRESS == LUNTC_OFS_CTRL && I_AVS_WRITEDATA[LUNTC_CTRL_FEAT_EN] |=> !O_MATRIX;
    endproperty
    a_enable_self: assert property (p_enable_self) else $error("Feature enable left matrix mode on."); // R17

    property p_zero_desel;
        I_CLK_EN && s.matrix && I_CMD.valid && I_CMD.vol != s.own_vol && !cfg_live(s) |=> O_LUN_STATE == LUNTC_ST_DESEL;
    endproperty
    a_zero_desel: assert property (p_zero_desel) else $error("Unconfigured LUN entered sniff state."); // R14

    c_matrix_entry: cover property (I_CLK_EN && I_CFG_CMD ##1 O_MATRIX);
    c_sniff_term: cover property (O_LUN_STATE == LUNTC_ST_SNIFF && O_TERM.dq_en);
    c_sel_term: cover property (O_LUN_STATE == LUNTC_ST_SEL && O_TERM.re_en);
    c_self_term: cover property (!O_MATRIX && O_TERM.dq_en);
    c_sel_input: cover property (O_LUN_STATE == LUNTC_ST_SEL && O_TERM.dq_en && !O_TERM.re_en);

endmodule : luntc_top

// >>> tb/luntc_host_model.sv
module luntc_host_model
    import luntc_pkg::*;
(
    input wire logic i_clk,
    output luntc_pins_t o_pins,
    output luntc_cmd_t o_cmd,
    output logic o_cfg_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl_re = 1'b0;
    logic tgl_dqs = 1'b0;
    initial begin
        o_pins = 5'b0_0_1_0_1;
        o_cmd = '0;
        o_cfg_cmd = 1'b0;
    end
    // Strobes run every cycle while the host moves data, and stand still otherwise.
    always @(posedge i_clk) begin
        if (tgl_re) begin
            o_pins.read_enable_n <= ~o_pins.read_enable_n;
        end
        if (tgl_dqs) begin
            o_pins.dqs <= ~o_pins.dqs;
        end
    end
    task automatic command(input logic [3:0] vol, input logic exec, input logic burst, input logic dir_out);
        @(posedge i_clk);
        o_pins.ce_n <= 1'b0;
        o_cmd <= {1'b1, vol, exec, burst, dir_out};
        @(posedge i_clk);
        o_cmd.valid <= 1'b0;
    endtask : command
    task automatic strobes(input logic re, input logic dqs);
        @(posedge i_clk);
        tgl_re <= re;
        tgl_dqs <= dqs;
    endtask : strobes
    task automatic latch(input logic ale);
        @(posedge i_clk);
        o_pins.ale <= ale;
    endtask : latch
    // One pulse reaches the target, which covers every target of this single-target bench.
    task automatic configure();
        @(posedge i_clk);
        o_cfg_cmd <= 1'b1;
        @(posedge i_clk);
        o_cfg_cmd <= 1'b0;
    endtask : configure
endmodule : luntc_host_model

// >>> tb/luntc_top_tb.sv
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module luntc_top_tb;
    import luntc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic waitreq;
    luntc_pins_t pins;
    luntc_cmd_t cmd;
    logic cfg;
    luntc_term_t term;
    luntc_lun_st_t lun_st;
    logic matrix;
    int bad_count = 0;
    int n_compared = 0;
    logic [4:0] ofs [8] = '{LUNTC_OFS_CTRL, LUNTC_OFS_MASK_LO, LUNTC_OFS_MASK_HI, LUNTC_OFS_DATA_CODE,
        LUNTC_OFS_RS_CODE, LUNTC_OFS_OWN_VOL, LUNTC_OFS_STATUS, 5'h1C};

    initial begin
        forever #4 clk = ~clk;
    end

    luntc_top DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en), .I_AVS_ADDRESS(address), .I_AVS_READ(read),
        .I_AVS_WRITE(write), .I_AVS_BYTEENABLE(be), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_PINS(pins), .I_CMD(cmd), .I_CFG_CMD(cfg), .O_TERM(term),
        .O_LUN_STATE(lun_st), .O_MATRIX(matrix));

    luntc_host_model host (.i_clk(clk), .o_pins(pins), .o_cmd(cmd), .o_cfg_cmd(cfg));

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // Holds the request until waitrequest is seen low at a rising edge, then releases it.
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b,
        output logic [31:0] q);
        int i;
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        be <= b;
        wdata <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitreq !== 1'b0 && i < 40);
        q = rdata;
        read <= 1'b0;
        write <= 1'b0;
        if (i >= 40) begin
            bad_count++;
            final_report();
        end
    endtask : av

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] ex);
        logic [31:0] q;
        av(1'b0, a, 32'h0000_0000, 4'hF, q);
        `CHK(nm, ex, q)
    endtask : rd_chk

    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    task automatic done(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, bad_count);
    endtask : done

    initial begin
        logic [31:0] q;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ofs[k]) rd_chk("reset value", ofs[k], LUNTC_RST_RDATA);
        `CHK("matrix after reset", 1'b0, matrix)
        `CHK("state after reset", LUNTC_ST_DESEL, lun_st)
        av(1'b1, LUNTC_OFS_DATA_CODE, 32'h0000_0042, 4'h0, q);
        rd_chk("lane 0 disabled", LUNTC_OFS_DATA_CODE, 32'h0000_0000);
        wr(LUNTC_OFS_OWN_VOL, 32'hFFFF_FFF5);
        rd_chk("own volume", LUNTC_OFS_OWN_VOL, 32'h0000_0005);
        wr(LUNTC_OFS_OWN_VOL, 32'h0000_0000);
        done("registers");
        wr(LUNTC_OFS_CTRL, 32'h0000_0001);
        host.command(4'h0, 1'b1, 1'b1, 1'b1);
        settle();
        `CHK("zero codes dq", 1'b0, term.dq_en)
        `CHK("zero codes re", 1'b0, term.re_en)
        wr(LUNTC_OFS_DATA_CODE, 32'h0000_0042);
        wr(LUNTC_OFS_RS_CODE, 32'h0000_0003);
        settle();
        `CHK("self output", 10'h293, term)
        rd_chk("status self", LUNTC_OFS_STATUS, 32'h0000_000D);
        host.command(4'h0, 1'b1, 1'b1, 1'b0);
        settle();
        `CHK("self input dq", 5'h12, term[9:5])
        `CHK("self input re", 1'b0, term.re_en)
        host.command(4'h0, 1'b0, 1'b1, 1'b1);
        settle();
        `CHK("not executing", 1'b0, term.dq_en)
        host.command(4'h0, 1'b1, 1'b1, 1'b1);
        host.latch(1'b1);
        settle();
        `CHK("latch rise self", 1'b0, term.dq_en)
        host.latch(1'b0);
        wr(LUNTC_OFS_CTRL, 32'h0000_0000);
        settle();
        `CHK("feature off", 1'b0, term.dq_en)
        done("self termination");
        wr(LUNTC_OFS_CTRL, 32'h0000_0001);
        host.configure();
        settle();
        `CHK("matrix on", 1'b1, matrix)
        wr(LUNTC_OFS_MASK_LO, 32'h0000_000C);
        wr(LUNTC_OFS_DATA_CODE, 32'h0000_0040);
        wr(LUNTC_OFS_RS_CODE, 32'h0000_0001);
        host.command(4'h2, 1'b0, 1'b0, 1'b1);
        settle();
        `CHK("sniff state", LUNTC_ST_SNIFF, lun_st)
        `CHK("sniff idle", 1'b0, term.dq_en)
        host.strobes(1'b1, 1'b0);
        settle();
        `CHK("sniff output", 10'h291, term)
        rd_chk("status sniff", LUNTC_OFS_STATUS, 32'h0000_001F);
        host.latch(1'b1);
        host.strobes(1'b0, 1'b0);
        settle();
        `CHK("sniff latch rise", 1'b0, term.dq_en)
        host.latch(1'b0);
        host.command(4'h1, 1'b0, 1'b0, 1'b1);
        host.strobes(1'b1, 1'b1);
        settle();
        `CHK("deselected state", LUNTC_ST_DESEL, lun_st)
        `CHK("deselected term", 1'b0, term.dq_en)
        host.strobes(1'b0, 1'b0);
        done("sniff");
        wr(LUNTC_OFS_MASK_LO, 32'h0000_000D);
        wr(LUNTC_OFS_DATA_CODE, 32'h0000_0042);
        host.command(4'h0, 1'b0, 1'b1, 1'b0);
        settle();
        `CHK("selected state", LUNTC_ST_SEL, lun_st)
        `CHK("selected input", 5'h12, term[9:5])
        host.command(4'h0, 1'b0, 1'b0, 1'b0);
        settle();
        `CHK("selected no burst", 1'b0, term.dq_en)
        wr(LUNTC_OFS_MASK_LO, 32'h0000_000C);
        host.command(4'h0, 1'b1, 1'b1, 1'b1);
        settle();
        `CHK("mask not covering", 1'b0, term.dq_en)
        wr(LUNTC_OFS_CTRL, 32'h0000_0005);
        settle();
        `CHK("back to self", 1'b0, matrix)
        `CHK("self again", 10'h291, term)
        @(posedge clk);
        clk_en <= 1'b0;
        host.latch(1'b1);
        settle();
        `CHK("frozen by enable", 10'h291, term)
        @(posedge clk);
        clk_en <= 1'b1;
        settle();
        `CHK("enable resumes", 1'b0, term.dq_en)
        host.latch(1'b0);
        done("matrix");
        final_report();
    end
endmodule : luntc_top_tb
